// ### verilog/divider_pkg.sv
// constants shared by the output channel divider files
package divider_pkg;
  // register indexes; byte address is four times the index
  localparam logic [9:0] idx_cycle_counts = 10'h190;
  localparam logic [9:0] idx_control = 10'h191;
  localparam logic [9:0] idx_routing = 10'h192;
  localparam logic [9:0] idx_driver = 10'h0f5;
  localparam logic [9:0] idx_status = 10'h1a0;
  localparam logic [11:0] addr_cycle_counts = {idx_cycle_counts, 2'b00};
  localparam logic [11:0] addr_control = {idx_control, 2'b00};
  localparam logic [11:0] addr_routing = {idx_routing, 2'b00};
  localparam logic [11:0] addr_driver = {idx_driver, 2'b00};
  localparam logic [11:0] addr_status = {idx_status, 2'b00};
  // reset values
  localparam logic [7:0] rst_cycle_counts = 8'h00;
  localparam logic [7:0] rst_control = 8'h80;
  localparam logic [7:0] rst_routing = 8'h00;
  localparam logic [7:0] rst_driver = 8'h0a;
  // field positions
  localparam int low_msb = 7;
  localparam int low_lsb = 4;
  localparam int high_msb = 3;
  localparam int high_lsb = 0;
  localparam int bypass_bit = 7;
  localparam int nosync_bit = 6;
  localparam int force_bit = 5;
  localparam int start_bit = 4;
  localparam int phase_msb = 3;
  localparam int phase_lsb = 0;
  localparam int direct_bit = 1;
  localparam int dcc_off_bit = 0;
  localparam int swing_msb = 3;
  localparam int swing_lsb = 2;
  localparam int power_msb = 1;
  localparam int power_lsb = 0;
  // source select codes and driver power codes
  localparam logic [1:0] src_osc = 2'b10;
  localparam logic [1:0] src_ext = 2'b00;
  localparam logic [1:0] pwr_normal = 2'b00;
  // divider run states
  typedef enum logic [0:0] {st_phase, st_run} div_state_t;
endpackage : divider_pkg

// ### verilog/div_core_if.sv
// link between the register side and the divider counter
`timescale 1ns/1ps
`default_nettype none
interface div_core_if;
  logic [4:0] hi_len;
  logic [4:0] lo_len;
  logic start_high;
  logic [3:0] phase;
  logic hold;
  logic in_rise;
  logic out;
  logic running;
  modport ctrl (output hi_len, lo_len, start_high, phase, hold, in_rise, input out, running);
  modport core (input hi_len, lo_len, start_high, phase, hold, in_rise, output out, running);
endinterface : div_core_if
`default_nettype wire

// ### verilog/div_counter.sv
// high/low cycle counter with phase offset
`timescale 1ns/1ps
`default_nettype none
module div_counter
  import divider_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  div_core_if.core dif
);
  div_state_t state_reg;
  logic [4:0] cnt_reg;
  logic [3:0] phase_reg;
  logic out_reg;
  logic [4:0] cur_len;

  // length of the phase now being counted
  assign cur_len = out_reg ? dif.hi_len : dif.lo_len;
  assign dif.out = out_reg;
  assign dif.running = (state_reg == st_run);

  // run state: wait out the phase offset, then divide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_phase;
      phase_reg <= 4'h0;
    end else if (dif.hold) begin
      state_reg <= st_phase;
      phase_reg <= dif.phase;
    end else if (dif.in_rise) begin
      case (state_reg)
        st_phase: begin
          // (RL12) phase offset delay
          if (phase_reg == 4'h0) begin
            state_reg <= st_run;
          end else begin
            phase_reg <= phase_reg - 4'h1;
          end
        end
        st_run: begin
          state_reg <= st_run;
        end
        default: begin
          state_reg <= st_phase;
        end
      endcase
    end
  end

  // output level and cycle count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 1'b0;
      cnt_reg <= 5'h00;
    end else if (dif.hold || state_reg != st_run) begin
      // (RL6) start level chosen
      out_reg <= dif.start_high;
      cnt_reg <= 5'h00;
    end else if (dif.in_rise) begin
      // (RL1) (RL2) (RL12) count+1 cycles each level
      if (cnt_reg + 5'h01 >= cur_len) begin
        out_reg <= ~out_reg;
        cnt_reg <= 5'h00;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end
endmodule : div_counter
`default_nettype wire

// ### verilog/output_channel_divider.sv
// output channel divider with apb registers and driver settings
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RL1) The output stays low for the upper nibble plus one input cycles, reset zero.
// (RL2) The output stays high for the lower nibble plus one input cycles, reset zero.
// (RL3) Bypass, set at reset, stops the divider and passes its input clock to the output.
// (RL4) With no-sync clear the divider obeys the chip sync, with it set it ignores sync.
// (RL5) The force bit holds the output high or low, only with no-sync set and bypass clear.
// (RL6) The start-level bit picks whether division begins low or high.
// (RL7) A four-bit phase offset, reset zero, sits in the control register.
// (RL8) Direct bit routes oscillator on source 10b, external clock on 00b, nothing on 01b.
// (RL9) Duty-cycle correction applies unless its disable bit is set.
// (RL10) A two-bit swing field selects 400, 600, 780 (reset) or 960 mV.
// (RL11) A two-bit power field selects normal, partial, safe partial (reset) or total power-down.
// (RL12) Period is high plus low time, and after sync the first edge waits the phase offset.
module output_channel_divider
  import divider_pkg::*;
#(
  parameter int addr_width = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_clk_in,
  input wire logic ext_clk_in,
  input wire logic [1:0] source_select,
  input wire logic sync_in,
  output logic first_output,
  output logic second_output,
  output logic [1:0] output_swing,
  output logic [1:0] output_power,
  output logic output_enable,
  output logic divider_powered
);
  // the decode below needs the full index range, and apb carries at most 32 address bits
  if (addr_width < 12) begin : g_width_low
    $error("addr_width must be at least 12");
  end
  if (addr_width > 32) begin : g_width_high
    $error("addr_width must be at most 32");
  end

  logic [7:0] cycle_counts_reg;
  logic [7:0] control_reg;
  logic [7:0] routing_reg;
  logic [7:0] driver_reg;
  logic ready_reg;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic div_in_reg;
  logic osc_reg;
  logic ext_reg;
  logic pair_reg;
  logic enable_reg;
  logic powered_reg;

  logic div_in;
  logic in_rise;
  logic bypass;
  logic nosync;
  logic force_hi;
  logic dcc_off;
  logic direct;
  logic [4:0] hi_raw;
  logic [4:0] lo_raw;
  logic [5:0] total;
  logic [4:0] hi_dcc;
  logic [4:0] lo_dcc;
  logic sel_hit;
  logic wr_go;
  logic rd_go;
  logic mapped;
  logic [7:0] rd_mux;
  logic [7:0] status;
  logic pair_next;
  logic sync_hold;
  logic force_hold;
  logic upper_zero;
  logic wr_counts;
  logic wr_control;
  logic wr_routing;
  logic wr_driver;
  logic dcc_active;
  logic power_on;
  logic [1:0] swing_field;
  logic [1:0] power_field;

  div_core_if dif ();

  div_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .dif(dif)
  );

  // field views of the control registers
  assign bypass = control_reg[bypass_bit];
  assign nosync = control_reg[nosync_bit];
  assign force_hi = control_reg[force_bit];
  assign dcc_off = routing_reg[dcc_off_bit];
  assign direct = routing_reg[direct_bit];
  assign hi_raw = {1'b0, cycle_counts_reg[high_msb:high_lsb]} + 5'h01;
  assign lo_raw = {1'b0, cycle_counts_reg[low_msb:low_lsb]} + 5'h01;

  // driver fields; the pair only drives in normal power
  assign swing_field = driver_reg[swing_msb:swing_lsb];
  assign power_field = driver_reg[power_msb:power_lsb];
  assign power_on = (power_field == pwr_normal);

  // the divider input is the selected source; osc for 10b, otherwise the external clock
  assign div_in = (source_select == src_osc) ? osc_clk_in : ext_clk_in;

  // input edge detect; inputs are already synchronous so one register suffices
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_in_reg <= 1'b0;
    end else begin
      div_in_reg <= div_in;
    end
  end
  // rises only when the source goes high, so a source idling low after reset gives no false edge
  assign in_rise = div_in & ~div_in_reg;

  // direct path copies; one flop each keeps both routes as late as the bypass route
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_reg <= 1'b0;
      ext_reg <= 1'b0;
    end else begin
      osc_reg <= osc_clk_in;
      ext_reg <= ext_clk_in;
    end
  end

  // duty correction splits the period evenly; odd periods give the extra cycle to low
  assign total = {1'b0, hi_raw} + {1'b0, lo_raw};
  assign hi_dcc = total[5:1];
  assign lo_dcc = 5'(total - {1'b0, total[5:1]});

  // counter configuration
  // (RL9) correction unless disabled
  assign dif.hi_len = dcc_off ? hi_raw : hi_dcc;
  assign dif.lo_len = dcc_off ? lo_raw : lo_dcc;
  // (RL6) start level
  assign dif.start_high = control_reg[start_bit];
  // (RL7) phase offset field
  assign dif.phase = control_reg[phase_msb:phase_lsb];
  assign dif.in_rise = in_rise;
  // (RL3) (RL4) bypass stops it; sync only when obeyed
  assign sync_hold = sync_in & ~nosync;
  // (RL5) nosync parks the counter while the forced level shows
  assign force_hold = nosync & ~bypass;
  assign dif.hold = bypass | sync_hold | force_hold;

  // pair level: direct route first, then bypass, then force, then divider
  always_comb begin
    pair_next = dif.out;
    if (direct && source_select == src_osc) begin
      // (RL8) oscillator straight out
      pair_next = osc_reg;
    end else if (direct && source_select == src_ext) begin
      // (RL8) external clock straight out
      pair_next = ext_reg;
    end else if (bypass) begin
      // (RL3) input passes through
      pair_next = div_in_reg;
    end else if (nosync) begin
      // (RL5) static forced level
      pair_next = force_hi;
    end
  end

  // (RL11) only normal mode enables the driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= 1'b0;
    end else begin
      enable_reg <= power_on;
    end
  end

  // (RL11) a powered-down pair rests low, so a partly powered driver sees no stray edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_reg <= 1'b0;
    end else begin
      pair_reg <= power_on ? pair_next : 1'b0;
    end
  end

  // (RL3) the divider is powered whenever bypass is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered_reg <= 1'b0;
    end else begin
      powered_reg <= ~bypass;
    end
  end

  // outputs straight from flops
  assign first_output = pair_reg;
  assign second_output = pair_reg;
  // (RL10) swing code to the driver
  assign output_swing = swing_field;
  // (RL11) power code to the driver
  assign output_power = power_field;
  assign output_enable = enable_reg;
  assign divider_powered = powered_reg;

  // apb handshake: one wait state, answer on the second access cycle
  assign sel_hit = psel & penable;
  assign wr_go = sel_hit & ready_reg & pwrite;
  assign rd_go = sel_hit & ~ready_reg & ~pwrite;

  // address decode
  always_comb begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    if (paddr[11:0] == addr_cycle_counts) begin
      rd_mux = cycle_counts_reg;
    end else if (paddr[11:0] == addr_control) begin
      rd_mux = control_reg;
    end else if (paddr[11:0] == addr_routing) begin
      rd_mux = routing_reg;
    end else if (paddr[11:0] == addr_driver) begin
      rd_mux = driver_reg;
    end else if (paddr[11:0] == addr_status) begin
      rd_mux = status;
    end else begin
      mapped = 1'b0;
    end
    // addresses above the index range alias nothing
    if (!upper_zero) begin
      mapped = 1'b0;
      rd_mux = 8'h00;
    end
  end
  assign upper_zero = ((paddr >> 12) == '0);

  // per-register write strobes; status has none, so writes to it are dropped
  always_comb begin
    wr_counts = 1'b0;
    wr_control = 1'b0;
    wr_routing = 1'b0;
    wr_driver = 1'b0;
    if (wr_go && upper_zero) begin
      if (paddr[11:0] == addr_cycle_counts) begin
        wr_counts = 1'b1;
      end else if (paddr[11:0] == addr_control) begin
        wr_control = 1'b1;
      end else if (paddr[11:0] == addr_routing) begin
        wr_routing = 1'b1;
      end else if (paddr[11:0] == addr_driver) begin
        wr_driver = 1'b1;
      end
    end
  end

  // read-only view of the block's own state
  assign dcc_active = ~dcc_off & ~bypass;
  assign status = {4'h0, enable_reg, dif.running, dcc_active, pair_reg};

  // ready: one wait state, then a single-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= sel_hit & ~ready_reg;
    end
  end

  // error rises with ready for an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= sel_hit & ~ready_reg & ~mapped;
    end
  end

  // read data loads in the wait cycle and clears once the bus goes idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_reg <= {24'h00_0000, rd_mux};
    end else if (!sel_hit) begin
      // held through the access so the ready edge always sees it
      rdata_reg <= 32'h0000_0000;
    end
  end
  assign prdata = rdata_reg;
  assign pready = ready_reg;
  assign pslverr = err_reg;

  // divider cycle counts register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // (RL1) (RL2) counts reset to zero
      cycle_counts_reg <= rst_cycle_counts;
    end else if (wr_counts) begin
      cycle_counts_reg <= pwdata[7:0];
    end
  end

  // divider control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // (RL3) bypass at reset
      control_reg <= rst_control;
    end else if (wr_control) begin
      control_reg <= pwdata[7:0];
    end
  end

  // routing register; unused upper bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routing_reg <= rst_routing;
    end else if (wr_routing) begin
      routing_reg <= {6'h00, pwdata[1:0]};
    end
  end

  // driver register; invert bit belongs elsewhere and reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // (RL10) (RL11) swing 780 mV, safe power-down
      driver_reg <= rst_driver;
    end else if (wr_driver) begin
      driver_reg <= {4'h0, pwdata[3:0]};
    end
  end
endmodule : output_channel_divider
`default_nettype wire

// ### tb/output_channel_divider_assertions.sv
// port level checks for the output channel divider
`timescale 1ns/1ps
`default_nettype none
module output_channel_divider_assertions
  import divider_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic first_output,
  input wire logic second_output,
  input wire logic [1:0] output_swing,
  input wire logic [1:0] output_power,
  input wire logic output_enable,
  input wire logic divider_powered
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a transfer is a setup cycle followed by an access cycle
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; setup_s ##1 (psel && penable); endsequence
  ready_timing_a: assert property (access_s |-> !pready ##1 pready) else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_a: assert property (!pready && !$past(pready) |-> prdata == 32'h0)
    else $error("stale read data");
  pair_same_a: assert property (first_output == second_output) else $error("pair split");
  // outputs settle one flop after the driver field
  power_off_a: assert property ((output_power != pwr_normal) [*3] |-> !output_enable && !first_output)
    else $error("powered down output active");
  power_on_a: assert property ((output_power == pwr_normal) [*3] |-> output_enable)
    else $error("output not enabled");
  bypass_write_a: assert property ($changed(divider_powered) |->
    ($past(pready) && $past(pwrite)) || ($past(pready, 2) && $past(pwrite, 2))) else $error("bypass moved alone");
  swing_write_a: assert property ($changed(output_swing) |->
    ($past(pready) && $past(pwrite)) || ($past(pready, 2) && $past(pwrite, 2))) else $error("swing moved alone");
endmodule // output_channel_divider_assertions
bind output_channel_divider output_channel_divider_assertions i_output_channel_divider_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .first_output(first_output), .second_output(second_output),
  .output_swing(output_swing), .output_power(output_power), .output_enable(output_enable),
  .divider_powered(divider_powered));
`default_nettype wire

// ### tb/output_channel_divider_tb.sv
// self-checking bench for the output channel divider
`timescale 1ns/1ps
`default_nettype none
module output_channel_divider_tb import divider_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, sync_in;
  logic osc_clk_in = 1'b0;
  logic ext_clk_in = 1'b0;
  logic [1:0] ext_cnt = 2'd0;
  logic pready, pslverr, first_output, second_output, output_enable, divider_powered;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] source_select, output_swing, output_power;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [3:0] hi, lo, ph;
  int mismatches, total_checks, th, tl, d0, d1, t;
  output_channel_divider i_output_channel_divider (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_clk_in(osc_clk_in),
    .ext_clk_in(ext_clk_in), .source_select(source_select), .sync_in(sync_in), .first_output(first_output),
    .second_output(second_output), .output_swing(output_swing), .output_power(output_power),
    .output_enable(output_enable), .divider_powered(divider_powered));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // osc flips each cycle, ext every third, so the two sources can be told apart
  always @(posedge pclk) begin
    osc_clk_in <= ~osc_clk_in;
    ext_cnt <= (ext_cnt == 2'd2) ? 2'd0 : ext_cnt + 2'd1;
    if (ext_cnt == 2'd2) ext_clk_in <= ~ext_clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // note layout: [33] compare data, [32] error expected, [31:0] read data
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] n);
    int k;
    notes.push_back(n);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {2'b10, e});
  endtask
  // compare each answer with the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      note = notes.pop_front();
      check({31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) check(prdata, note[31:0]);
    end
  end
  // cycles the pair stays at level v; a stuck pair ends the run
  task automatic run_at(input logic v, output int n);
    n = 0;
    while (first_output === v && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) begin
      mismatches++;
      stop_test();
    end
  endtask
  // skip the partial phases, then time one full high and low
  task automatic measure();
    run_at(1'b1, th);
    run_at(1'b0, tl);
    run_at(1'b1, th);
    run_at(1'b0, tl);
  endtask
  task automatic sync_delay(input logic [3:0] p, output int d);
    wr(addr_control, {28'h0, p});
    sync_in <= 1'b1;
    repeat (12) @(posedge pclk);
    check({31'h0, first_output}, 32'h0);
    if (osc_clk_in !== 1'b1) @(posedge pclk);
    sync_in <= 1'b0;
    run_at(1'b0, d);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, sync_in} = 5'h0;
    {paddr, pwdata, source_select} = {44'h0, src_osc};
    mismatches = 0;
    total_checks = 0;
    void'($urandom(27111));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(addr_cycle_counts, 32'h0);
    rd(addr_control, 32'h80);
    rd(addr_routing, 32'h0);
    rd(addr_driver, 32'h0a);
    apb(1'b1, 12'h008, 32'hff, {2'b01, 32'h0});
    apb(1'b0, 12'h004, 32'h0, {2'b11, 32'h0});
    check({31'h0, first_output}, 32'h0);
    // every swing and power code, ending on normal power
    for (int i = 0; i < 4; i++) begin
      wr(addr_driver, 3 * i + 3);
      repeat (3) @(posedge pclk);
      check({30'h0, output_swing}, i);
      check({30'h0, output_power}, 3 - i);
      check({31'h0, output_enable}, i == 3);
    end
    measure();
    check(th + tl, 2);
    check({31'h0, divider_powered}, 32'h0);
    check({31'h0, second_output}, {31'h0, first_output});
    wr(addr_control, 32'h0);
    for (int i = 0; i < 3; i++) begin
      hi = $urandom;
      lo = $urandom;
      wr(addr_cycle_counts, {24'h0, lo, hi});
      rd(addr_cycle_counts, {24'h0, lo, hi});
      wr(addr_routing, 32'h1);
      measure();
      measure();
      check({31'h0, divider_powered}, 32'h1);
      check(th, 2 * (hi + 1));
      check(tl, 2 * (lo + 1));
      wr(addr_routing, 32'h0);
      measure();
      measure();
      t = lo + hi + 2;
      check(th, 2 * (t / 2));
      check(tl, 2 * (t - t / 2));
    end
    wr(addr_cycle_counts, 32'h0);
    wr(addr_routing, 32'h1);
    sync_delay(4'h0, d0);
    ph = $urandom | 4'h1;
    sync_delay(ph, d1);
    check(d1 - d0, 2 * ph);
    // start level under sync, then force with and without bypass
    wr(addr_control, 32'h10);
    sync_in <= 1'b1;
    repeat (12) @(posedge pclk);
    check({31'h0, first_output}, 32'h1);
    wr(addr_control, 32'h50);
    repeat (4) @(posedge pclk);
    check({31'h0, first_output}, 32'h0);
    wr(addr_control, 32'h70);
    repeat (4) @(posedge pclk);
    check({31'h0, first_output}, 32'h1);
    wr(addr_control, 32'hf0);
    measure();
    check(th, 1);
    sync_in <= 1'b0;
    wr(addr_control, 32'h0);
    wr(addr_cycle_counts, 32'h33);
    wr(addr_routing, 32'h2);
    // direct path: osc, ext, then no effect with ext feeding the divider
    for (int i = 0; i < 3; i++) begin
      source_select <= (i == 0) ? src_osc : (i == 1) ? src_ext : 2'b01;
      measure();
      measure();
      t = (i == 0) ? 1 : (i == 1) ? 3 : 24;
      check(th, t);
      check(tl, t);
    end
    stop_test();
  end
endmodule // output_channel_divider_tb
`default_nettype wire
